// ---- rtl/soo_core.sv ----
// soo_core: safety output override logic with APB register access
// assumes inputs are already debounced and synchronous to clk; run means the device is in its Run state
// What this block does
// - mute plus bypass turns blocked outputs on
// - override holds after clears and bypass opening
// - mute lamp flashes when stopped and muted
// - bypass to Run: outputs on, lamp steady
// - bypass timer expiry turns outputs off
// - bypass Stop then Run starts new bypass
// - other input Stop turns output off
// - no mute: off in Stop, bypass Run on
// - remain-on option keeps delayed output after cancel
// - manual input re-close: delayed output off, stays
// - auto input re-close: off 500 ms, on
// - enabling Run in Run state with outputs on enters enable mode; not during bypass
// - enabling Stop turns outputs off
// - enabling timer expiry turns outputs off
// - enabling Stop then Run turns outputs on
// - E-stop Stop forces outputs off in enable mode
// - enabling Stop plus reset leaves enable mode
//
// The implementer's own choices: the register offsets and the APB register port.
`default_nettype none
module soo_core #(
   parameter int unsigned MS_CYC    = soo_pkg::CLK_HZ / 1000,
   parameter int unsigned AUTO_CYC  = soo_pkg::AUTO_OFF_CYC,
   parameter int unsigned FLASH_CYC = soo_pkg::FLASH_HALF_CYC
) (
   input  wire logic                     clk,
   input  wire logic                     rstn,
   input  wire soo_pkg::soo_apb_req_type apb_req,
   output logic                          pready,
   output logic [31:0]                   prdata,
   output logic                          pslverr,
   input  wire soo_pkg::soo_in_type      din,
   output soo_pkg::soo_out_type          dout
);
   initial if (AUTO_CYC < 1 || FLASH_CYC < 1) $error("soo_core: cycle counts must be at least 1");

   typedef enum logic [4:0] {
      ST_IDLE   = 5'b00001,
      ST_RUN    = 5'b00010,
      ST_BYPASS = 5'b00100,
      ST_MDO    = 5'b01000,
      ST_ENABLE = 5'b10000
   } soo_state_type;

   logic [31:0]   ctrl_r;
   logic [31:0]   byp_ms_r;
   logic [31:0]   ena_ms_r;
   logic [31:0]   off_ms_r;
   soo_state_type st_r;
   soo_state_type st_nxt;
   logic          byp_prev_r;
   logic          ena_prev_r;
   logic          reset_prev_r;
   logic          ena_seen_stop_r;
   logic          out_on;
   logic          any_mute;
   logic          byp_rise;
   logic          ena_rise;
   logic          reset_rise;
   logic          byp_start;
   logic          ena_start;
   logic          byp_running;
   logic          byp_done;
   logic          ena_running;
   logic          ena_done;
   logic          guard_ok;
   logic          wr_en;
   logic [31:0]   flash_cnt_r;
   logic          flash_r;

   assign any_mute   = din.mute_a | din.mute_b;
   assign byp_rise   = din.bypass_run & ~byp_prev_r;
   assign ena_rise   = din.enable_run & ~ena_prev_r;
   assign reset_rise = din.reset_btn & ~reset_prev_r;
   assign guard_ok   = din.screen_run & din.other_run & din.estop_run;

   // apb slave: zero wait states, unmapped addresses read zero and flag an error
   assign pready = 1'b1;
   assign wr_en  = apb_req.psel & apb_req.penable & apb_req.pwrite;

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == soo_pkg::ADDR_CTRL) || (a == soo_pkg::ADDR_STATUS) || (a == soo_pkg::ADDR_BYPT) ||
               (a == soo_pkg::ADDR_ENAT) || (a == soo_pkg::ADDR_OFFT);
   endfunction : mapped

   assign pslverr = apb_req.psel & apb_req.penable & ~mapped(apb_req.paddr);

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         ctrl_r   <= soo_pkg::CTRL_RST;
         byp_ms_r <= 32'(soo_pkg::BYP_TIME_MS_DEF);
         ena_ms_r <= 32'(soo_pkg::ENA_TIME_MS_DEF);
         off_ms_r <= 32'(soo_pkg::OFFDLY_MS_DEF);
      end
      else if (wr_en)
      begin
         case (apb_req.paddr)
            soo_pkg::ADDR_CTRL: ctrl_r   <= apb_req.pwdata & 32'h0000_000f;
            soo_pkg::ADDR_BYPT: byp_ms_r <= apb_req.pwdata;
            soo_pkg::ADDR_ENAT: ena_ms_r <= apb_req.pwdata;
            soo_pkg::ADDR_OFFT: off_ms_r <= apb_req.pwdata;
            default:            ctrl_r   <= ctrl_r;
         endcase
      end
   end

   // delayed output state, declared before the read mux uses it
   logic        dly_on_r;
   logic        dly_run_r;
   logic        dly_kept_r;
   logic        auto_off_r;
   logic [31:0] auto_cnt_r;
   logic        dly_done;
   logic        dly_running;
   logic        dly_start;

   always_ff @(posedge clk)
   begin
      if (!rstn)
         prdata <= 32'h0;
      else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite)
      begin
         case (apb_req.paddr)
            soo_pkg::ADDR_CTRL:   prdata <= ctrl_r;
            soo_pkg::ADDR_STATUS: prdata <= {22'h0, auto_off_r, dly_run_r, dly_on_r, flash_r,
                                             st_r, dout.safety_out};
            soo_pkg::ADDR_BYPT:   prdata <= byp_ms_r;
            soo_pkg::ADDR_ENAT:   prdata <= ena_ms_r;
            soo_pkg::ADDR_OFFT:   prdata <= off_ms_r;
            default:              prdata <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         byp_prev_r   <= 1'b0;
         ena_prev_r   <= 1'b0;
         reset_prev_r <= 1'b0;
      end
      else
      begin
         byp_prev_r   <= din.bypass_run;
         ena_prev_r   <= din.enable_run;
         reset_prev_r <= din.reset_btn;
      end
   end

   soo_timer #(.MS_CYC(MS_CYC)) u_byp_tmr (
      .clk     (clk),
      .rstn    (rstn),
      .start   (byp_start),
      .stop    (~din.bypass_run),
      .dur_ms  (byp_ms_r),
      .running (byp_running),
      .done    (byp_done)
   );

   soo_timer #(.MS_CYC(MS_CYC)) u_ena_tmr (
      .clk     (clk),
      .rstn    (rstn),
      .start   (ena_start),
      .stop    (~din.enable_run | ((st_r == ST_ENABLE) & ~guard_ok)),
      .dur_ms  (ena_ms_r),
      .running (ena_running),
      .done    (ena_done)
   );

   always_comb
   begin
      st_nxt    = st_r;
      byp_start = 1'b0;
      ena_start = 1'b0;
      case (st_r)
         ST_IDLE:
         begin
            if (guard_ok && !din.enable_run && (ctrl_r[soo_pkg::CTRL_AUTO_RST] || reset_rise))
               st_nxt = ST_RUN;
            else if (byp_rise && din.other_run && din.estop_run)
            begin
               byp_start = 1'b1;
               if (ctrl_r[soo_pkg::CTRL_MDO_EN] && ctrl_r[soo_pkg::CTRL_MUTE_EN] && any_mute &&
                   !din.screen_run)
                  st_nxt = ST_MDO;
               else
                  st_nxt = ST_BYPASS;
            end
         end
         ST_RUN:
         begin
            if (!din.other_run || !din.estop_run)
               st_nxt = ST_IDLE;
            else if (!din.screen_run)
               st_nxt = ST_IDLE;
            else if (ena_rise)
            begin
               ena_start = 1'b1;
               st_nxt    = ST_ENABLE;
            end
         end
         ST_BYPASS:
         begin
            if (!din.other_run || !din.estop_run)
               st_nxt = ST_IDLE;
            else if (byp_done || !din.bypass_run)
               st_nxt = ST_IDLE;
         end
         ST_MDO:
         begin
            // the override holds once started; only other guards or the bypass timer drop it
            if (!din.other_run || !din.estop_run)
               st_nxt = ST_IDLE;
            else if (byp_done)
               st_nxt = ST_IDLE;
            else if (din.screen_run && !any_mute && !din.bypass_run)
               st_nxt = ST_RUN;
         end
         ST_ENABLE:
         begin
            if (reset_rise && !din.enable_run && ena_seen_stop_r)
               st_nxt = guard_ok ? ST_RUN : ST_IDLE;
            else if (ena_rise && guard_ok)
               ena_start = 1'b1;
         end
         default:
            st_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         st_r <= ST_IDLE;
      else
         st_r <= st_nxt;
   end

   always_ff @(posedge clk)
   begin
      if (!rstn || st_r != ST_ENABLE)
         ena_seen_stop_r <= 1'b0;
      else if (!din.enable_run)
         ena_seen_stop_r <= 1'b1;
   end

   // enable mode output: only while enabling device held, timer live, guards ok
   always_comb
   begin
      case (st_r)
         ST_RUN:    out_on = 1'b1;
         ST_BYPASS: out_on = 1'b1;
         ST_MDO:    out_on = 1'b1;
         ST_ENABLE: out_on = din.enable_run & ena_running & guard_ok;
         default:   out_on = 1'b0;
      endcase
   end

   // mute lamp flash; the divider free-runs so the pattern never stalls
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         flash_cnt_r <= 32'h0;
         flash_r     <= 1'b0;
      end
      else if (flash_cnt_r == FLASH_CYC - 1)
      begin
         flash_cnt_r <= 32'h0;
         flash_r     <= ~flash_r;
      end
      else
         flash_cnt_r <= flash_cnt_r + 32'h1;
   end

   // off-delay output follows the main output with a delay and a cancel input
   soo_timer #(.MS_CYC(MS_CYC)) u_off_tmr (
      .clk     (clk),
      .rstn    (rstn),
      .start   (dly_start),
      .stop    (1'b0),
      .dur_ms  (off_ms_r),
      .running (dly_running),
      .done    (dly_done)
   );

   assign dly_start = dly_on_r & ~dly_run_r & ~out_on & ~auto_off_r & ~dly_kept_r;

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         dly_on_r   <= 1'b0;
         dly_run_r  <= 1'b0;
         dly_kept_r <= 1'b0;
         auto_off_r <= 1'b0;
         auto_cnt_r <= 32'h0;
      end
      else if (auto_off_r)
      begin
         if (auto_cnt_r == AUTO_CYC - 1)
         begin
            auto_off_r <= 1'b0;
            dly_on_r   <= out_on;
         end
         else
            auto_cnt_r <= auto_cnt_r + 32'h1;
      end
      else if (dly_run_r)
      begin
         if (ctrl_r[soo_pkg::CTRL_REMAIN] && din.cancel_dly && out_on)
         begin
            dly_run_r  <= 1'b0;
            dly_kept_r <= 1'b1;
         end
         else if (!ctrl_r[soo_pkg::CTRL_REMAIN] && guard_ok)
         begin
            dly_run_r <= 1'b0;
            dly_on_r  <= 1'b0;
            if (ctrl_r[soo_pkg::CTRL_AUTO_RST])
            begin
               auto_off_r <= 1'b1;
               auto_cnt_r <= 32'h0;
            end
         end
         else if (dly_done)
         begin
            dly_run_r <= 1'b0;
            dly_on_r  <= 1'b0;
         end
      end
      else if (dly_start)
         dly_run_r <= 1'b1;
      else
      begin
         if (!out_on)
            dly_kept_r <= 1'b0;
         // manual input: output returns only after the main output comes back, through a reset or a bypass
         if (out_on)
            dly_on_r <= 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         dout <= '0;
      else
      begin
         dout.safety_out  <= out_on;
         dout.delayed_out <= dly_on_r | dly_kept_r;
         dout.enable_mode <= (st_nxt == ST_ENABLE);
         if (st_nxt == ST_MDO || st_nxt == ST_BYPASS)
            dout.mute_lamp <= ctrl_r[soo_pkg::CTRL_MUTE_EN] & any_mute;
         else if (st_nxt == ST_IDLE && !din.screen_run && ctrl_r[soo_pkg::CTRL_MUTE_EN])
            dout.mute_lamp <= any_mute & flash_r;
         else
            dout.mute_lamp <= 1'b0;
      end
   end
endmodule : soo_core
`default_nettype wire

// ---- rtl/soo_pkg.sv ----
// soo_pkg: constants, register map and carrier types for the safety output override logic
// assumes a 125 MHz clock; all offsets are APB byte addresses
`default_nettype none
package soo_pkg;
   localparam int unsigned CLK_HZ            = 125000000;
   localparam int unsigned AUTO_OFF_MS       = 500;
   localparam int unsigned AUTO_OFF_CYC      = AUTO_OFF_MS * (CLK_HZ / 1000);
   localparam int unsigned BYP_TIME_MS_DEF   = 10000;
   localparam int unsigned ENA_TIME_MS_DEF   = 10000;
   localparam int unsigned OFFDLY_MS_DEF     = 2000;
   localparam int unsigned FLASH_HALF_MS     = 250;
   localparam int unsigned FLASH_HALF_CYC    = FLASH_HALF_MS * (CLK_HZ / 1000);

   localparam logic [11:0] ADDR_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_BYPT   = 12'h008;
   localparam logic [11:0] ADDR_ENAT   = 12'h00c;
   localparam logic [11:0] ADDR_OFFT   = 12'h010;

   // control register bit positions
   localparam int unsigned CTRL_MDO_EN   = 0;
   localparam int unsigned CTRL_REMAIN   = 1;
   localparam int unsigned CTRL_AUTO_RST = 2;
   localparam int unsigned CTRL_MUTE_EN  = 3;
   localparam logic [31:0] CTRL_RST      = 32'h0000_0009;

   typedef struct packed {
      logic screen_run;
      logic mute_a;
      logic mute_b;
      logic bypass_run;
      logic enable_run;
      logic estop_run;
      logic other_run;
      logic cancel_dly;
      logic reset_btn;
   } soo_in_type;

   typedef struct packed {
      logic safety_out;
      logic delayed_out;
      logic mute_lamp;
      logic enable_mode;
   } soo_out_type;

   typedef struct packed {
      logic [11:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } soo_apb_req_type;
endpackage : soo_pkg
`default_nettype wire

// ---- rtl/soo_timer.sv ----
// soo_timer: millisecond down-counter with restart; done pulses when the count runs out
// assumes a free-running clock and a prescale that yields one tick per millisecond
`default_nettype none
module soo_timer #(
   parameter int unsigned MS_CYC = 125000
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        start,
   input  wire logic        stop,
   input  wire logic [31:0] dur_ms,
   output logic             running,
   output logic             done
);
   initial if (MS_CYC < 1) $error("soo_timer: MS_CYC must be at least 1");
   logic [31:0] pre_r;
   logic [31:0] ms_r;

   always_ff @(posedge clk)
   begin
      if (!rstn || stop)
      begin
         running <= 1'b0;
         done    <= 1'b0;
         pre_r   <= 32'h0;
         ms_r    <= 32'h0;
      end
      else if (start)
      begin
         running <= 1'b1;
         done    <= 1'b0;
         pre_r   <= 32'h0;
         ms_r    <= dur_ms;
      end
      else
      begin
         done <= 1'b0;
         if (running)
         begin
            if (pre_r == MS_CYC - 1)
            begin
               pre_r <= 32'h0;
               if (ms_r <= 32'h1)
               begin
                  running <= 1'b0;
                  done    <= 1'b1;
               end
               else
                  ms_r <= ms_r - 32'h1;
            end
            else
               pre_r <= pre_r + 32'h1;
         end
      end
   end
endmodule : soo_timer
`default_nettype wire

// ---- testbench/soo_core_properties.sv ----
// soo_core_properties: port-level checker for the override logic
// assumes it is bound to soo_core and that inputs move one edge at a time
`default_nettype none
module soo_core_chk (
   input wire logic                     clk,
   input wire logic                     rstn,
   input wire soo_pkg::soo_apb_req_type apb_req,
   input wire logic                     pready,
   input wire logic                     pslverr,
   input wire soo_pkg::soo_in_type      din,
   input wire soo_pkg::soo_out_type     dout
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   property p_err;
      pslverr |-> apb_req.psel && apb_req.penable && pready;
   endproperty
   a_err: assert property (p_err) else $error("slave error outside access");
   property p_oth;
      $fell(din.other_run) |-> ##[1:3] !dout.safety_out;
   endproperty
   a_oth: assert property (p_oth) else $error("other stop left output on");
   property p_est;
      $fell(din.estop_run) |-> ##[1:3] !dout.safety_out;
   endproperty
   a_est: assert property (p_est) else $error("stop input left output on");
   property p_ens;
      dout.enable_mode && $fell(din.enable_run) |-> ##[1:3] !dout.safety_out;
   endproperty
   a_ens: assert property (p_ens) else $error("enabling stop left output on");
   property p_enr;
      dout.safety_out && !din.bypass_run && $rose(din.enable_run) |-> ##[1:3] dout.enable_mode && dout.safety_out;
   endproperty
   a_enr: assert property (p_enr) else $error("enable mode not entered");
   property p_enx;
      dout.enable_mode && !din.enable_run && $rose(din.reset_btn) |-> ##[1:3] !dout.enable_mode;
   endproperty
   a_enx: assert property (p_enx) else $error("enable mode not left");
   property p_byp;
      $rose(din.bypass_run) && !dout.safety_out && din.estop_run && din.other_run && !din.enable_run
         |-> ##[1:3] dout.safety_out;
   endproperty
   a_byp: assert property (p_byp) else $error("bypass did not turn output on");
   property p_dly;
      $fell(dout.safety_out) && dout.delayed_out |=> dout.delayed_out;
   endproperty
   a_dly: assert property (p_dly) else $error("delayed output dropped at once");
   c_ena: cover property ($rose(dout.enable_mode));
   c_dly: cover property ($fell(dout.delayed_out));
   c_err: cover property (pslverr);
endmodule : soo_core_chk
bind soo_core soo_core_chk u_chk (.clk(clk), .rstn(rstn), .apb_req(apb_req), .pready(pready),
   .pslverr(pslverr), .din(din), .dout(dout));
`default_nettype wire

// ---- testbench/soo_field.sv ----
// soo_field: field devices in front of the block; switch levels pass through, except reset_btn, which comes from press
// assumes the bench sets switch levels and asks for reset presses
`default_nettype none
module soo_field (
   input wire logic                clk,
   input wire soo_pkg::soo_in_type sw,
   input wire logic                press,
   output var soo_pkg::soo_in_type din
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] hold_r = 3'h0;
   // a press keeps the contact closed a few cycles, as a real button does
   always_ff @(posedge clk)
   begin
      hold_r <= press ? 3'h4 : (hold_r != 3'h0 ? hold_r - 3'h1 : 3'h0);
   end
   always_comb
   begin
      din = sw;
      din.reset_btn = hold_r != 3'h0;
   end
endmodule : soo_field
`default_nettype wire

// ---- testbench/tb.sv ----
// tb: self-checking bench for soo_core behind a field-device model
// assumes short timer parameters; every wait below is derived from them
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                     clk = 1'b0;
   logic                     rstn = 1'b0;
   logic                     press = 1'b0;
   logic                     pready;
   logic                     pslverr;
   logic [31:0]              prdata;
   logic [31:0]              seed = 32'h0000_1cf4;
   int                       error_cnt = 0;
   int                       checks_done = 0;
   int                       n;
   logic                     qe[$];
   soo_pkg::soo_apb_req_type req = '0;
   soo_pkg::soo_in_type      sw = 9'h10c;
   soo_pkg::soo_in_type      din;
   soo_pkg::soo_out_type     dout;
   soo_field u_fld (.clk(clk), .sw(sw), .press(press), .din(din));
   soo_core #(.MS_CYC(10), .AUTO_CYC(50), .FLASH_CYC(4)) u_dut (.clk(clk), .rstn(rstn), .apb_req(req),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .din(din), .dout(dout));
   initial forever #4 clk = ~clk;
   task end_sim();
      if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim
   task fail(input string m);
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
   endtask : fail
   task cmp_b(input logic g, input logic e, input string m);
      checks_done++;
      if (g !== e) fail(m);
   endtask : cmp_b
   task cmp_w(input logic [31:0] g, input logic [31:0] e, input string m);
      checks_done++;
      if (g !== e) fail(m);
   endtask : cmp_w
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task step(input int k);
      repeat (k) @(posedge clk);
   endtask : step
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e, input logic ee);
      @(posedge clk);
      req <= '{a, 1'b1, 1'b0, w, d};
      @(posedge clk);
      req.penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      if (!w) cmp_w(prdata, e, "read data");
      cmp_b(pslverr, ee, "slave error");
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb
   // upper control bits carry noise; only the low four may stick
   task wctl(input logic [3:0] v);
      apb(1'b1, soo_pkg::ADDR_CTRL, (rnd() & 32'hffff_fff0) | {28'h0, v}, 32'h0, 1'b0);
      apb(1'b0, soo_pkg::ADDR_CTRL, 32'h0, {28'h0, v}, 1'b0);
   endtask : wctl
   task note(input logic v);
      qe.push_back(v);
   endtask : note
   task sync();
      for (int i = 0; i < 80 && qe.size() != 0; i++) @(posedge clk);
      if (qe.size() != 0) fail("output change missing");
      qe.delete();
   endtask : sync
   task push_rst();
      @(posedge clk);
      press <= 1'b1;
      @(posedge clk);
      press <= 1'b0;
   endtask : push_rst
   task lamp(output int t);
      logic p;
      t = 0;
      p = dout.mute_lamp;
      repeat (24)
      begin
         @(posedge clk);
         if (dout.mute_lamp !== p) t++;
         p = dout.mute_lamp;
      end
   endtask : lamp
   initial forever
   begin
      @(dout.safety_out);
      if (rstn === 1'b1)
      begin
         if (qe.size() == 0) fail("unexpected output change");
         else cmp_b(dout.safety_out, qe.pop_front(), "safety output");
      end
   end
   initial
   begin
      step(20000);
      fail("timeout");
      end_sim();
   end
   initial
   begin
      step(12);
      rstn <= 1'b1;
      apb(1'b0, soo_pkg::ADDR_CTRL, 32'h0, soo_pkg::CTRL_RST, 1'b0);
      apb(1'b0, 12'h100, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 12'h100, rnd(), 32'h0, 1'b1);
      apb(1'b1, soo_pkg::ADDR_BYPT, 32'h5, 32'h0, 1'b0);
      apb(1'b1, soo_pkg::ADDR_ENAT, 32'h5, 32'h0, 1'b0);
      apb(1'b1, soo_pkg::ADDR_OFFT, 32'h3, 32'h0, 1'b0);
      apb(1'b0, soo_pkg::ADDR_BYPT, 32'h0, 32'h5, 1'b0);
      note(1'b1);
      push_rst();
      sync();
      note(1'b0);
      @(posedge clk) sw.screen_run <= 1'b0;
      sync();
      @(posedge clk) sw.mute_a <= 1'b1;
      note(1'b1);
      @(posedge clk) sw.bypass_run <= 1'b1;
      sync();
      @(posedge clk) sw.screen_run <= 1'b1;
      @(posedge clk) sw.mute_a <= 1'b0;
      @(posedge clk) sw.bypass_run <= 1'b0;
      step(20);
      cmp_b(dout.safety_out, 1'b1, "override dropped");
      wctl(4'h0);
      note(1'b0);
      @(posedge clk) sw.screen_run <= 1'b0;
      sync();
      note(1'b1);
      @(posedge clk) sw.bypass_run <= 1'b1;
      sync();
      step(35);
      note(1'b0);
      sync();
      @(posedge clk) sw.bypass_run <= 1'b0;
      step(2 + int'(rnd() & 32'h3));
      note(1'b1);
      @(posedge clk) sw.bypass_run <= 1'b1;
      sync();
      note(1'b0);
      @(posedge clk) sw.other_run <= 1'b0;
      sync();
      @(posedge clk) sw.bypass_run <= 1'b0;
      @(posedge clk) sw.other_run <= 1'b1;
      @(posedge clk) sw.screen_run <= 1'b1;
      note(1'b1);
      push_rst();
      sync();
      wctl(4'h8);
      note(1'b0);
      @(posedge clk) sw.screen_run <= 1'b0;
      sync();
      @(posedge clk) sw.mute_a <= 1'b1;
      lamp(n);
      cmp_b(n > 1, 1'b1, "lamp not flashing");
      note(1'b1);
      @(posedge clk) sw.bypass_run <= 1'b1;
      sync();
      lamp(n);
      cmp_b(n == 0 && dout.mute_lamp === 1'b1, 1'b1, "lamp not steady");
      note(1'b0);
      @(posedge clk) sw.bypass_run <= 1'b0;
      sync();
      @(posedge clk) sw.mute_a <= 1'b0;
      @(posedge clk) sw.screen_run <= 1'b1;
      note(1'b1);
      push_rst();
      sync();
      @(posedge clk) sw.enable_run <= 1'b1;
      step(4);
      cmp_b(dout.enable_mode, 1'b1, "enable mode missing");
      note(1'b0);
      @(posedge clk) sw.enable_run <= 1'b0;
      sync();
      note(1'b1);
      @(posedge clk) sw.enable_run <= 1'b1;
      sync();
      step(35);
      note(1'b0);
      sync();
      @(posedge clk) sw.enable_run <= 1'b0;
      step(3);
      note(1'b1);
      @(posedge clk) sw.enable_run <= 1'b1;
      sync();
      note(1'b0);
      @(posedge clk) sw.estop_run <= 1'b0;
      sync();
      @(posedge clk) sw.estop_run <= 1'b1;
      @(posedge clk) sw.enable_run <= 1'b0;
      note(1'b1);
      push_rst();
      sync();
      cmp_b(dout.enable_mode, 1'b0, "enable mode kept");
      wctl(4'h0);
      note(1'b0);
      @(posedge clk) sw.screen_run <= 1'b0;
      sync();
      step(3);
      cmp_b(dout.delayed_out, 1'b1, "off-delay missing");
      @(posedge clk) sw.screen_run <= 1'b1;
      step(3);
      cmp_b(dout.delayed_out, 1'b0, "delayed output kept");
      step(40);
      cmp_b(dout.delayed_out, 1'b0, "delayed output back");
      note(1'b1);
      push_rst();
      sync();
      wctl(4'h4);
      note(1'b0);
      @(posedge clk) sw.screen_run <= 1'b0;
      sync();
      note(1'b1);
      @(posedge clk) sw.screen_run <= 1'b1;
      sync();
      step(2);
      cmp_b(dout.delayed_out, 1'b0, "no blank after re-close");
      step(30);
      cmp_b(dout.delayed_out, 1'b0, "blank too short");
      step(40);
      cmp_b(dout.delayed_out, 1'b1, "not back on after blank");
      wctl(4'h6);
      note(1'b0);
      @(posedge clk) sw.screen_run <= 1'b0;
      sync();
      note(1'b1);
      @(posedge clk) sw.screen_run <= 1'b1;
      sync();
      @(posedge clk) sw.cancel_dly <= 1'b1;
      @(posedge clk) sw.cancel_dly <= 1'b0;
      n = 0;
      repeat (40) @(posedge clk) n += int'(dout.delayed_out !== 1'b1);
      cmp_b(n == 0, 1'b1, "cancelled delay dropped output");
      end_sim();
   end
endmodule : tb
`default_nettype wire
